// ==== pic_top.sv ====
// Purpose: Prioritized interrupt controller with APB register access
// Assumes: One clock, asynchronous active-low reset
// Notes:   Sequencer acknowledges a vector with vec_take
//
// Chosen here: register access over APB and the register addresses.
module pic_top
    import pic_pkg::*;
#(
    parameter int NFLAG = 2
)
(
    // APB
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [31:0]            prdata,
    // Sources
    input  wire logic              emu_irq,
    input  wire logic              reset_irq,
    input  wire logic              pwrdn_irq,
    input  wire logic              kernel_irq,
    input  wire logic [14:0]       periph_irq,
    input  wire logic [NFLAG-1:0]  flag_pin,
    input  wire logic              no_boot_ext,
    // PC stack level and loop stack event from sequencer
    input  wire logic [5:0]        pc_stack_level,
    input  wire logic              loop_stack_event,
    // Sequencer handshake
    input  wire logic              vec_take,
    input  wire logic              rti_done,
    output logic                   vec_req,
    output logic [23:0]            vec_addr,
    output logic                   emu_req
);
    typedef struct packed
    {
        logic [15:0]            control;
        logic [15:0]            mask;
        logic [15:0]            pending;
        logic [59:0]            prio;
        logic [NFLAG-1:0]       fl_out;
        logic [NFLAG-1:0]       fl_drv;
        logic [2*NFLAG-1:0]     fl_mode;
        logic [15:0]            active;
        logic                   pready;
        logic                   pslverr;
        logic [31:0]            prdata;
        logic                   vec_req;
        logic [23:0]            vec_addr;
        logic [3:0]             vec_pos;
        logic                   emu_req;
    } pic_state_t;

    pic_state_t st;
    pic_state_t next_st;
    logic [NFLAG-1:0] flag_irq;
    logic [15:0]      raise;
    logic [15:0]      eligible;
    logic [15:0]      active_top;
    logic             found;
    logic [3:0]       win;
    logic             pc_stk;
    logic             wr;
    logic             rd;

    // ------------------------------------------------------------
    // Flag pins
    // ------------------------------------------------------------
    // flag detect per pin
    genvar g;
    generate
        for (g = 0; g < NFLAG; g++)
        begin : gen_flag
            pic_flag_detect u_fd
            (
                .pclk      (pclk),
                .presetn   (presetn),
                .pin       (flag_pin[g]),
                .is_output (st.fl_out[g]),
                .sw_drive  (st.fl_drv[g]),
                .mode      (st.fl_mode[2*g +: 2]),
                .irq       (flag_irq[g])
            );
        end
    endgenerate

    assign wr = psel & penable & pwrite & st.pready;
    assign rd = psel & ~penable & ~pwrite;

    // ------------------------------------------------------------
    // Combinational next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [14:0] src;
        logic [3:0]  p;
        logic [3:0]  pos;
        logic        en_blk;
        p        = '0;
        pos      = '0;
        en_blk   = 1'b0;
        next_st  = st;
        src      = periph_irq;
        // Any flag is ORed into peripheral id 12; flag 1 is also ORed into id 13
        src[12]  = src[12] | (|flag_irq);
        src[13]  = src[13] | flag_irq[NFLAG-1];
        pc_stk   = (pc_stack_level < 6'(PC_STACK_LO)) | (pc_stack_level > 6'(PC_STACK_HI));
        raise    = '0;
        raise[POS_RESET]  = reset_irq;
        raise[POS_PWRDN]  = pwrdn_irq;
        raise[POS_STACK]  = (pc_stk & st.control[BIT_PCSTK_EN])
                          | (loop_stack_event & st.control[BIT_LPSTK_EN]);
        raise[POS_KERNEL] = kernel_irq;
        for (int i = 0; i < NUM_PERIPH; i++)
        begin
            p = st.prio[4*i +: 4];
            // level 11 aliases to position 15
            pos = (p >= PRIO_ALIAS) ? POS_ALIAS : 4'(p + 4'(POS_USER0));
            if (src[i])
                raise[pos] = 1'b1;
        end
        // global enable gates maskable and power-down
        en_blk = st.control[BIT_GIE];
        // reset and power-down skip the mask
        eligible = st.pending & st.mask;
        eligible[POS_RESET] = st.pending[POS_RESET];
        eligible[POS_PWRDN] = st.pending[POS_PWRDN] & en_blk;
        for (int i = 2; i < 16; i++)
            eligible[i] = eligible[i] & en_blk;
        // nesting admits only higher priority than active
        active_top = '0;
        for (int i = 15; i >= 0; i--)
            if (st.active[i])
                active_top = 16'(16'h0001 << i);
        for (int i = 0; i < 16; i++)
        begin
            if (st.active != '0)
            begin
                if (!st.control[BIT_NEST] && i != POS_RESET)
                    eligible[i] = 1'b0;
                else if ((16'(16'h0001 << i)) >= active_top && i != POS_RESET)
                    eligible[i] = 1'b0;
            end
        end
        found = 1'b0;
        win   = '0;
        for (int i = 15; i >= 0; i--)
            if (eligible[i])
            begin
                found = 1'b1;
                win   = 4'(i);
            end
        // software latch write, set beats clear for new events
        next_st.pending = st.pending;
        if (wr && paddr == OFF_PENDING)
            next_st.pending = pwdata[15:0];
        if (vec_take && st.vec_req)
            next_st.pending[st.vec_pos] = 1'b0;
        next_st.pending = next_st.pending | raise;
        if (vec_take && st.vec_req)
            next_st.active[st.vec_pos] = 1'b1;
        if (rti_done)
            next_st.active = st.active & ~active_top;
        next_st.emu_req = emu_irq;
        next_st.vec_req  = found & ~(vec_take & st.vec_req);
        next_st.vec_pos  = win;
        next_st.vec_addr = (24'(win) << VEC_STEP_SH)
                         | (no_boot_ext ? VEC_NOBOOT : 24'h00_0000);
        // APB no wait states, pready registered from setup
        next_st.pready  = psel & ~penable;
        next_st.pslverr = 1'b0;
        if (wr)
        begin
            case (paddr)
                OFF_CONTROL: next_st.control = pwdata[15:0] & CONTROL_WMASK;
                OFF_MASK:    next_st.mask    = pwdata[15:0];
                OFF_PENDING: ;
                OFF_PRIO0:   next_st.prio[15:0]  = pwdata[15:0];
                OFF_PRIO1:   next_st.prio[31:16] = pwdata[15:0];
                OFF_PRIO2:   next_st.prio[47:32] = pwdata[15:0];
                OFF_PRIO3:   next_st.prio[59:48] = pwdata[11:0];
                OFF_FLAGCFG:
                begin
                    next_st.fl_out  = pwdata[NFLAG-1:0];
                    next_st.fl_drv  = pwdata[8 +: NFLAG];
                    next_st.fl_mode = pwdata[16 +: 2*NFLAG];
                end
                OFF_COMMAND:
                begin
                    if (pwdata[0])
                        next_st.control[BIT_GIE] = 1'b1;
                    if (pwdata[1])
                        next_st.control[BIT_GIE] = 1'b0;
                end
                OFF_STATUS:  next_st.pslverr = 1'b1;
                default:     next_st.pslverr = 1'b1;
            endcase
        end
        if (rd)
        begin
            case (paddr)
                OFF_CONTROL: next_st.prdata = {16'h0000, st.control};
                OFF_MASK:    next_st.prdata = {16'h0000, st.mask};
                OFF_PENDING: next_st.prdata = {16'h0000, st.pending};
                OFF_PRIO0:   next_st.prdata = {16'h0000, st.prio[15:0]};
                OFF_PRIO1:   next_st.prdata = {16'h0000, st.prio[31:16]};
                OFF_PRIO2:   next_st.prdata = {16'h0000, st.prio[47:32]};
                OFF_PRIO3:   next_st.prdata = {20'h0_0000, st.prio[59:48]};
                OFF_FLAGCFG: next_st.prdata = 32'({st.fl_mode, 8'(st.fl_drv), 8'(st.fl_out)});
                OFF_STATUS:  next_st.prdata = {11'h000, found, win, st.active};
                default:     next_st.prdata = 32'h0000_0000;
            endcase
        end
        if (psel && !penable && !(paddr inside {OFF_CONTROL, OFF_MASK, OFF_PENDING,
            OFF_PRIO0, OFF_PRIO1, OFF_PRIO2, OFF_PRIO3, OFF_FLAGCFG, OFF_STATUS,
            OFF_COMMAND}))
            next_st.pslverr = 1'b1;
        else if (psel && !penable && pwrite && paddr == OFF_STATUS)
            next_st.pslverr = 1'b1;
        else if (psel && !penable)
            next_st.pslverr = 1'b0;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // reset priorities equal id, 12..14 at 11
    // stack depths held by sequencer, sized in package
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st         <= '0;
            st.control <= RST_CONTROL;
            st.mask    <= RST_MASK;
            st.prio    <= 60'hBBB_BA98_7654_3210;
        end
        else
            st <= next_st;
    end

    assign pready   = st.pready;
    assign pslverr  = st.pslverr;
    assign prdata   = st.prdata;
    assign vec_req  = st.vec_req;
    assign vec_addr = st.vec_addr;
    assign emu_req  = st.emu_req;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_vec_spacing: assert property (vec_req |-> vec_addr[4:0] == 5'h00)
        else $error("vector not on 0x20 step");
    a_noboot_ofs: assert property (vec_req && $past(no_boot_ext) |-> vec_addr[16])
        else $error("no-boot offset missing");
    a_gie_block: assert property (!st.control[BIT_GIE] && vec_req |-> st.vec_pos == 0)
        else $error("serviced while disabled");
    a_take_clear: assert property (vec_take && vec_req && st.vec_pos != 0 && !raise[st.vec_pos]
        && !wr |=> !st.pending[$past(st.vec_pos)])
        else $error("latch not cleared");
    a_raise_set: assert property (reset_irq |=> st.pending[POS_RESET])
        else $error("event lost");
    a_emu_follow: assert property (emu_irq |=> emu_req)
        else $error("emulator not passed");
    a_alias_pos: assert property (periph_irq[14] && st.prio[59:56] == PRIO_ALIAS
        |=> st.pending[POS_ALIAS])
        else $error("alias position wrong");
    a_no_nest: assert property (!st.control[BIT_NEST] && st.active != 0 && vec_req
        |-> st.vec_pos == 0)
        else $error("nested while off");
    a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb timing wrong");
    c_take: cover property (vec_req && vec_take);
    c_nest: cover property (st.active != 0 && vec_req);
    c_emu: cover property (emu_req);
endmodule

// ==== pic_pkg.sv ====
// Purpose: Constants and types for the prioritized interrupt controller
// Assumes: 16-bit registers, APB word-aligned register map
// Notes:   Register offsets are byte addresses
package pic_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_CONTROL   = 12'h000;
    localparam logic [11:0] OFF_MASK      = 12'h004;
    localparam logic [11:0] OFF_PENDING   = 12'h008;
    localparam logic [11:0] OFF_PRIO0     = 12'h00C;
    localparam logic [11:0] OFF_PRIO1     = 12'h010;
    localparam logic [11:0] OFF_PRIO2     = 12'h014;
    localparam logic [11:0] OFF_PRIO3     = 12'h018;
    localparam logic [11:0] OFF_FLAGCFG   = 12'h01C;
    localparam logic [11:0] OFF_STATUS    = 12'h020;
    localparam logic [11:0] OFF_COMMAND   = 12'h024;
    // ------------------------------------------------------------
    // Control bits and resets
    // ------------------------------------------------------------
    localparam int          BIT_NEST      = 4;
    localparam int          BIT_GIE       = 5;
    localparam int          BIT_PCSTK_EN  = 10;
    localparam int          BIT_LPSTK_EN  = 11;
    localparam logic [15:0] CONTROL_WMASK = 16'h0CB0;
    localparam logic [15:0] RST_CONTROL   = 16'h0000;
    localparam logic [15:0] RST_MASK      = 16'h0000;
    // Positions
    localparam int          POS_RESET     = 0;
    localparam int          POS_PWRDN     = 1;
    localparam int          POS_STACK     = 2;
    localparam int          POS_KERNEL    = 3;
    localparam int          POS_USER0     = 4;
    localparam logic [3:0]  PRIO_ALIAS    = 4'h0B;
    localparam logic [3:0]  POS_ALIAS     = 4'hF;
    localparam int          NUM_PERIPH    = 15;
    // Vectors
    localparam logic [23:0] VEC_STEP_SH   = 24'h00_0005;
    localparam logic [23:0] VEC_NOBOOT    = 24'h01_0000;
    // Stacks
    localparam int          PC_STACK_LO   = 3;
    localparam int          PC_STACK_HI   = 28;
    localparam int          PC_STACK_DEPTH = 33;
    localparam int          LP_STACK_DEPTH = 8;
    localparam int          ST_STACK_DEPTH = 16;
    // Flag detect modes
    typedef enum logic [1:0]
    {
        PIC_LEVEL = 2'b00,
        PIC_EDGE  = 2'b01,
        PIC_BOTH  = 2'b10
    } pic_flag_mode_t;
endpackage

// ==== pic_flag_detect.sv ====
// Purpose: One programmable flag pin interrupt detector
// Assumes: Pin synchronous to pclk
// Notes:   Level mode follows pin; edge modes emit a one-cycle pulse
module pic_flag_detect
    import pic_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Pin and config
    input  wire logic       pin,
    input  wire logic       is_output,
    input  wire logic       sw_drive,
    input  wire logic [1:0] mode,
    // Result
    output logic            irq
);
    typedef struct packed
    {
        logic prev;
        logic irq;
    } pic_fd_t;
    pic_fd_t st;
    pic_fd_t next_st;
    logic    val;

    always_comb
    begin
        next_st = st;
        // Output pin drives its own value for a software interrupt
        val = is_output ? sw_drive : pin;
        next_st.prev = val;
        case (mode)
            PIC_LEVEL: next_st.irq = val;
            PIC_EDGE:  next_st.irq = val & ~st.prev;
            PIC_BOTH:  next_st.irq = val ^ st.prev;
            default:   next_st.irq = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end
    assign irq = st.irq;
endmodule

// ==== pic_seq_model.sv ====
// Purpose: Sequencer stand-in that takes vectors and returns from them
// Assumes: A vector is taken only while vec_req is high
// Notes:   Take delay alternates 0 and 3 cycles; no nested takes
module pic_seq_model
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Handshake
    input  wire logic vec_req,
    output logic      vec_take,
    output logic      rti_done
);
    timeunit 1ns;
    timeprecision 100ps;
    int   wait_c;
    int   svc_c;
    logic slow;
    // ------------------------------------------------------------
    // Take and return
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vec_take <= 1'b0;
            rti_done <= 1'b0;
            wait_c   <= 0;
            svc_c    <= 0;
            slow     <= 1'b0;
        end
        else
        begin
            vec_take <= 1'b0;
            rti_done <= 1'b0;
            // Busy service blocks a second take, so the bench sees them in order
            if (svc_c > 0)
            begin
                svc_c    <= svc_c - 1;
                rti_done <= (svc_c == 1);
            end
            else if (vec_req && !vec_take)
            begin
                if (wait_c >= (slow ? 3 : 0))
                begin
                    vec_take <= 1'b1;
                    svc_c    <= 8;
                    wait_c   <= 0;
                    slow     <= !slow;
                end
                else
                    wait_c <= wait_c + 1;
            end
        end
    end
endmodule

// ==== test_prioritized_interrupt_controller.sv ====
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Zero-wait APB slave, sequencer model on the far side
// Notes:   Results are queued by drivers and matched by a monitor
module test_prioritized_interrupt_controller;
    timeunit 1ns;
    timeprecision 100ps;
    import pic_pkg::*;
    typedef struct {logic [1:0] kind; logic [32:0] val;} pic_exp_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic emu_irq, reset_irq, pwrdn_irq, kernel_irq, no_boot_ext;
    logic loop_stack_event, vec_take, rti_done, vec_req, emu_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [14:0] periph_irq;
    logic [1:0]  flag_pin;
    logic [5:0]  pc_stack_level;
    logic [23:0] vec_addr;
    logic [3:0]  p;
    logic        nb;
    int          seed, r, mismatches, n_tests;
    pic_exp_t    exp_q[$];
    pic_top #(.NFLAG(2)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .emu_irq(emu_irq),
        .reset_irq(reset_irq), .pwrdn_irq(pwrdn_irq), .kernel_irq(kernel_irq),
        .periph_irq(periph_irq), .flag_pin(flag_pin), .no_boot_ext(no_boot_ext),
        .pc_stack_level(pc_stack_level), .loop_stack_event(loop_stack_event),
        .vec_take(vec_take), .rti_done(rti_done), .vec_req(vec_req),
        .vec_addr(vec_addr), .emu_req(emu_req));
    pic_seq_model seq_u (.pclk(pclk), .presetn(presetn), .vec_req(vec_req),
        .vec_take(vec_take), .rti_done(rti_done));
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    task automatic check(input logic [34:0] got, input logic [34:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic note(input logic [1:0] k, input logic [32:0] v);
        pic_exp_t e;
        e.kind = k;
        e.val  = v;
        exp_q.push_back(e);
    endtask
    // Writes only compare the error flag
    task automatic take(input logic [1:0] k, input logic [32:0] got);
        pic_exp_t e;
        e.kind = 2'd3;
        e.val  = 33'h0;
        if (exp_q.size() > 0)
            e = exp_q.pop_front();
        check({k, (k == 2'd1) ? {got[32], 32'h0} : got}, {e.kind, e.val});
    endtask
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1)
            take(pwrite ? 2'd1 : 2'd0, {pslverr, prdata});
        if (vec_req === 1'b1 && vec_take)
            take(2'd2, {9'h0, vec_addr});
    end
    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic er);
        int i;
        @(posedge pclk);
        note(w ? 2'd1 : 2'd0, w ? {er, 32'h0} : {er, d});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= w ? d : 32'h0;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'b1 && i < 50);
        if (i >= 50)
            finish_fail();
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic finish_fail;
        mismatches++;
        finish_test();
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d);
        apb(1'b0, a, d, 1'b0);
    endtask
    task automatic vec(input logic [23:0] v);
        note(2'd2, {9'h0, v});
    endtask
    // Bounded wait for queued results, then room for the return
    task automatic drain;
        int i;
        for (i = 0; i < 300 && exp_q.size() != 0; i++)
            @(posedge pclk);
        if (i >= 300)
            finish_fail();
        repeat (12) @(posedge pclk);
    endtask
    task automatic quiet(input int n);
        repeat (n)
        begin
            @(negedge pclk);
            check({34'h0, vec_req}, 35'h0);
        end
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {presetn, psel, penable, pwrite, emu_irq, reset_irq, pwrdn_irq} = 7'h00;
        {kernel_irq, no_boot_ext, loop_stack_event, paddr, pwdata} = 47'h0;
        {periph_irq, flag_pin, nb} = 18'h0;
        pc_stack_level = 6'd10;
        mismatches = 0;
        n_tests = 0;
        seed = 25624;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_CONTROL, 32'(RST_CONTROL));
        rd(OFF_MASK, 32'(RST_MASK));
        rd(OFF_PRIO0, 32'h0000_3210);
        rd(OFF_PRIO1, 32'h0000_7654);
        rd(OFF_PRIO2, 32'h0000_BA98);
        rd(OFF_PRIO3, 32'h0000_0BBB);
        apb(1'b0, 12'h0FC, 32'h0000_0000, 1'b1);
        apb(1'b1, OFF_STATUS, 32'h0000_FFFF, 1'b1);
        $display("test registers done");
        vec(24'h00_0000);
        reset_irq <= 1'b1;
        @(posedge pclk);
        reset_irq <= 1'b0;
        emu_irq   <= 1'b1;
        @(posedge pclk);
        emu_irq <= 1'b0;
        @(negedge pclk);
        check({34'h0, emu_req}, 35'h1);
        drain();
        $display("test reset and emulator done");
        wr(OFF_MASK, 32'h0000_FFFF);
        periph_irq[3] <= 1'b1;
        @(posedge pclk);
        periph_irq[3] <= 1'b0;
        quiet(20);
        // Note vectors only after the write returns, so queue order matches
        wr(OFF_CONTROL, 32'h0000_0030);
        vec(24'h00_00E0);
        drain();
        wr(OFF_PENDING, 32'h0000_0240);
        vec(24'h00_00C0);
        vec(24'h00_0120);
        drain();
        wr(OFF_MASK, 32'h0000_0040);
        wr(OFF_PENDING, 32'h0000_0240);
        vec(24'h00_00C0);
        drain();
        rd(OFF_PENDING, 32'h0000_0200);
        wr(OFF_PENDING, 32'h0000_0000);
        rd(OFF_PENDING, 32'h0000_0000);
        $display("test enable and mask done");
        wr(OFF_COMMAND, 32'h0000_0002);
        pwrdn_irq <= 1'b1;
        @(posedge pclk);
        pwrdn_irq <= 1'b0;
        quiet(20);
        wr(OFF_COMMAND, 32'h0000_0001);
        vec(24'h00_0020);
        drain();
        $display("test power-down done");
        wr(OFF_MASK, 32'h0000_FFFF);
        for (int n = 4; n < 16; n++)
        begin
            r = $random(seed);
            nb = r[4];
            no_boot_ext <= nb;
            wr(OFF_PENDING, 32'h1 << n);
            vec({15'h0, 4'(n), 5'h0} + (nb ? VEC_NOBOOT : 24'h00_0000));
            drain();
        end
        no_boot_ext <= 1'b0;
        $display("test vector table done");
        for (int id = 0; id < NUM_PERIPH; id++)
        begin
            r = $random(seed);
            p = (id == 14) ? PRIO_ALIAS : r[3:0] % 4'd12;
            wr(OFF_PRIO0 + 12'(4 * (id / 4)), 32'(p) << (4 * (id % 4)));
            rd(OFF_PRIO0 + 12'(4 * (id / 4)), 32'(p) << (4 * (id % 4)));
            vec({15'h0, 4'(p + 4'd4), 5'h0});
            periph_irq[id] <= 1'b1;
            @(posedge pclk);
            periph_irq[id] <= 1'b0;
            drain();
        end
        $display("test peripheral priority done");
        wr(OFF_CONTROL, 32'h0000_0C30);
        for (int k = 0; k < 4; k++)
        begin
            vec((k == 3) ? 24'h00_0060 : 24'h00_0040);
            @(posedge pclk);
            pc_stack_level   <= (k == 0) ? 6'd2 : (k == 1) ? 6'd29 : 6'd10;
            loop_stack_event <= (k == 2);
            kernel_irq       <= (k == 3);
            @(posedge pclk);
            {pc_stack_level, loop_stack_event, kernel_irq} <= {6'd10, 2'b00};
            drain();
        end
        $display("test stack and kernel done");
        wr(OFF_PRIO3, 32'h0000_0BBB);
        wr(OFF_FLAGCFG, 32'h0001_0000);
        vec(24'h00_01E0);
        flag_pin[0] <= 1'b1;
        drain();
        quiet(10);
        $display("test flag pin done");
        finish_test();
    end
endmodule
